// file: icto_map.vh
// Purpose: constants for the two-wire clock, count, timeout and address buffer block
// Assumes: AXI4-Lite word registers; byte address is four times the index
// Notes: indexes are the printed offsets
`ifndef ICTO_MAP_VH
`define ICTO_MAP_VH
`define ICTO_IDX_CNT      12'h28C
`define ICTO_IDX_ADB0     12'h28E
`define ICTO_IDX_ADB1     12'h28F
`define ICTO_IDX_ERR      12'h297
`define ICTO_IDX_BTO      12'h29C
`define ICTO_IDX_BAUD     12'h29D
`define ICTO_IDX_CLK      12'h29E
`define ICTO_IDX_BTOC     12'h29F
`define ICTO_IDX_STAT     12'h2A0
`define ICTO_RST_BAUD     8'h00
`define ICTO_RST_CLK      4'h0
`define ICTO_RST_BTOC     3'h0
`define ICTO_BTO_REC      7
`define ICTO_BTO_BY32     6
`define ICTO_ERR_BUS_TIMEOUT_FLAG    6
`define ICTO_ERR_NACK_DETECT_FLAG   4
`define ICTO_ERR_BUS_TIMEOUT_IRQ_ENABLE    2
`define ICTO_ERR_NACK_DETECT_IRQ_ENABLE   0
`define ICTO_TO_MULT      11'h020
`define ICTO_RESP_OKAY    2'h0
`define ICTO_RESP_SLVERR  2'h2
`endif

// file: icto_core.v
// Purpose: module clock select, prescaler, byte counter, bus timeout, address buffers
// Assumes: SCL event strobes and mode come from the serial engine on core_clk
// Notes: external clock sources are sampled through two flops and edge detected
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "icto_map.vh"
module icto_core (
  // Clock and reset
  input  wire        core_clk,
  input  wire        srst,
  // AXI4-Lite slave
  input  wire [13:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [13:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Clock sources, asynchronous: index 2..13 of module select
  input  wire [13:2] module_clk_src,
  // Timeout sources, asynchronous: index 1..5 of timeout select
  input  wire [5:1]  timeout_clk_src,
  // Serial engine state and events; event strobes are one-cycle pulses
  input  wire [2:0]  mode,
  input  wire        receiving,
  input  wire        scl_fall_8th,
  input  wire        scl_fall_9th,
  input  wire        nack_seen,
  input  wire        nack_addr_mismatch,
  input  wire        transmit_write_error,
  input  wire        receive_read_error,
  input  wire        transmit_underflow,
  input  wire        receive_overflow,
  input  wire        bus_busy,
  input  wire        addr_low_valid,
  input  wire        addr_high_valid,
  input  wire [7:0]  addr_rx_byte,
  // Outputs to the serial engine and system
  output reg         prescaled_clk_tick,
  output reg         count_done_flag,
  output reg         serial_module_reset,
  output reg         error_irq_request,
  output reg  [7:0]  tx_address_byte,
  output reg  [7:0]  tx_address_low
);
  reg  [15:0] byte_counter;
  reg  [7:0]  address_buffer_low;
  reg  [7:0]  address_buffer_high;
  reg  [7:0]  bus_timeout_setup;
  reg  [7:0]  baud_prescaler;
  reg  [3:0]  module_clock_select;
  reg  [2:0]  timeout_clock_select;
  reg         nack_detect_flag;
  reg         bus_timeout_flag;
  reg         nack_detect_irq_enable;
  reg         bus_timeout_irq_enable;
  reg  [13:2] mclk_s1;
  reg  [13:2] mclk_s2;
  reg  [13:2] mclk_s3;
  reg  [5:1]  tclk_s1;
  reg  [5:1]  tclk_s2;
  reg  [5:1]  tclk_s3;
  reg  [1:0]  div4_cnt;
  reg  [7:0]  baud_cnt;
  reg  [10:0] to_cnt;
  reg         mclk_edge;
  reg         tclk_edge;
  reg  [10:0] to_limit;
  // Write channel holding
  reg         aw_held;
  reg         w_held;
  reg  [11:0] aw_idx;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        wr_go;
  wire [11:0] ar_idx;
  wire        ctrl_mode;
  wire        wr_cnt;
  wire        wr_err;
  wire        cnt_dec;
  wire        timeout_hit;
  wire        nack_event;
  wire        wr_map;
  wire        in_map_ar;
  wire        nack_irq_src;
  wire        bto_irq_src;
  wire [10:0] to_next;

  assign wr_go     = aw_held && w_held && !s_axi_bvalid;
  assign ar_idx    = s_axi_araddr[13:2];
  assign ctrl_mode = mode[2] && !mode[1];
  assign wr_cnt    = wr_go && (aw_idx == `ICTO_IDX_CNT);
  assign wr_err    = wr_go && (aw_idx == `ICTO_IDX_ERR) && w_strb[0];
  assign wr_map    = (aw_idx == `ICTO_IDX_CNT) || (aw_idx == `ICTO_IDX_ADB0) ||
                     (aw_idx == `ICTO_IDX_ADB1) || (aw_idx == `ICTO_IDX_ERR) ||
                     (aw_idx == `ICTO_IDX_BTO) || (aw_idx == `ICTO_IDX_BAUD) ||
                     (aw_idx == `ICTO_IDX_CLK) || (aw_idx == `ICTO_IDX_BTOC) ||
                     (aw_idx == `ICTO_IDX_STAT);
  assign in_map_ar = (ar_idx == `ICTO_IDX_CNT) || (ar_idx == `ICTO_IDX_ADB0) ||
                     (ar_idx == `ICTO_IDX_ADB1) || (ar_idx == `ICTO_IDX_ERR) ||
                     (ar_idx == `ICTO_IDX_BTO) || (ar_idx == `ICTO_IDX_BAUD) ||
                     (ar_idx == `ICTO_IDX_CLK) || (ar_idx == `ICTO_IDX_BTOC) ||
                     (ar_idx == `ICTO_IDX_STAT);
  assign cnt_dec   = receiving ? scl_fall_8th : scl_fall_9th;
  assign nack_event = (nack_seen && !nack_addr_mismatch) ||
                      transmit_write_error || receive_read_error ||
                      transmit_underflow || receive_overflow;
  assign to_next     = to_cnt + 11'h001;
  assign timeout_hit = tclk_edge && bus_busy && (to_next >= to_limit) &&
                       (to_limit != 11'h000);
  assign nack_irq_src = nack_detect_flag && nack_detect_irq_enable;
  assign bto_irq_src  = bus_timeout_flag && bus_timeout_irq_enable;

  // Source synchronisers, edge taken from second and third flops
  always @(posedge core_clk) begin
    if (srst) begin
      mclk_s1 <= 12'h000;
      mclk_s2 <= 12'h000;
      mclk_s3 <= 12'h000;
      tclk_s1 <= 5'h00;
      tclk_s2 <= 5'h00;
      tclk_s3 <= 5'h00;
    end else begin
      mclk_s1 <= module_clk_src;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
      tclk_s1 <= timeout_clk_src;
      tclk_s2 <= tclk_s1;
      tclk_s3 <= tclk_s2;
    end
  end

  // Module clock edge select
  always @* begin
    case (module_clock_select)
      4'h0: mclk_edge = (div4_cnt == 2'h3);
      4'h1: mclk_edge = 1'b1;
      4'hE, 4'hF: mclk_edge = 1'b0;
      default: mclk_edge = mclk_s2[module_clock_select] && !mclk_s3[module_clock_select];
    endcase
  end

  // Timeout clock edge select
  always @* begin
    case (timeout_clock_select)
      3'h0, 3'h6, 3'h7: tclk_edge = 1'b0;
      default: tclk_edge = tclk_s2[timeout_clock_select] && !tclk_s3[timeout_clock_select];
    endcase
    if (bus_timeout_setup[`ICTO_BTO_BY32])
      to_limit = {5'h00, bus_timeout_setup[5:0]};
    else
      to_limit = {bus_timeout_setup[5:0], 5'h00};
  end

  // Prescaler and timeout counter
  always @(posedge core_clk) begin
    if (srst) begin
      div4_cnt           <= 2'h0;
      baud_cnt           <= 8'h00;
      prescaled_clk_tick <= 1'b0;
      to_cnt             <= 11'h000;
      serial_module_reset <= 1'b0;
    end else begin
      div4_cnt <= div4_cnt + 2'h1;
      prescaled_clk_tick <= 1'b0;
      if (mclk_edge) begin
        if (baud_cnt >= baud_prescaler) begin
          baud_cnt           <= 8'h00;
          prescaled_clk_tick <= 1'b1;
        end else begin
          baud_cnt <= baud_cnt + 8'h01;
        end
      end
      // Timeout counter, cleared while bus idle
      serial_module_reset <= timeout_hit && bus_timeout_setup[`ICTO_BTO_REC];
      if (!bus_busy || timeout_hit)
        to_cnt <= 11'h000;
      else if (tclk_edge)
        to_cnt <= to_next;
    end
  end

  // AXI write path
  always @(posedge core_clk) begin
    if (srst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ICTO_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `ICTO_RESP_OKAY : `ICTO_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Registers and events
  always @(posedge core_clk) begin
    if (srst) begin
      byte_counter           <= 16'h0000;
      address_buffer_low     <= 8'h00;
      address_buffer_high    <= 8'h00;
      bus_timeout_setup      <= 8'h00;
      baud_prescaler         <= `ICTO_RST_BAUD;
      module_clock_select    <= `ICTO_RST_CLK;
      timeout_clock_select   <= `ICTO_RST_BTOC;
      nack_detect_flag       <= 1'b0;
      bus_timeout_flag       <= 1'b0;
      nack_detect_irq_enable <= 1'b0;
      bus_timeout_irq_enable <= 1'b0;
      count_done_flag        <= 1'b0;
    end else begin
      // Configuration writes
      if (wr_go) begin
        case (aw_idx)
          `ICTO_IDX_BTO:  if (w_strb[0]) bus_timeout_setup <= w_data[7:0];
          `ICTO_IDX_BAUD: if (w_strb[0]) baud_prescaler <= w_data[7:0];
          `ICTO_IDX_CLK:  if (w_strb[0]) module_clock_select <= w_data[3:0];
          `ICTO_IDX_BTOC: if (w_strb[0]) timeout_clock_select <= w_data[2:0];
          `ICTO_IDX_ADB0: if (w_strb[0] && mode == 3'h5)
            address_buffer_low <= w_data[7:0];
          `ICTO_IDX_ADB1: if (w_strb[0] && mode[2])
            address_buffer_high <= w_data[7:0];
          `ICTO_IDX_ERR: if (w_strb[0]) begin
            nack_detect_irq_enable <= w_data[`ICTO_ERR_NACK_DETECT_IRQ_ENABLE];
            bus_timeout_irq_enable <= w_data[`ICTO_ERR_BUS_TIMEOUT_IRQ_ENABLE];
          end
          default: ;
        endcase
      end
      // Byte counter, software write wins
      if (wr_cnt) begin
        if (w_strb[0])
          byte_counter[7:0] <= w_data[7:0];
        if (w_strb[1])
          byte_counter[15:8] <= w_data[15:8];
      end else if (cnt_dec && byte_counter != 16'h0000) begin
        byte_counter <= byte_counter - 16'h0001;
      end
      // Count flag, set wins over clear
      if (scl_fall_9th && byte_counter == 16'h0000)
        count_done_flag <= 1'b1;
      else if (wr_go && aw_idx == `ICTO_IDX_STAT && w_strb[0] && w_data[0])
        count_done_flag <= 1'b0;
      // Address capture in target and multi-controller modes
      if (!mode[2] || mode[1]) begin
        if (addr_low_valid)
          address_buffer_low <= addr_rx_byte;
        if (addr_high_valid && mode[2:1] == 2'b01)
          address_buffer_high <= addr_rx_byte;
      end
      // Flags: set wins over software clear of zero written
      if (nack_event)
        nack_detect_flag <= 1'b1;
      else if (wr_err)
        nack_detect_flag <= w_data[`ICTO_ERR_NACK_DETECT_FLAG];
      if (timeout_hit)
        bus_timeout_flag <= 1'b1;
      else if (wr_err)
        bus_timeout_flag <= w_data[`ICTO_ERR_BUS_TIMEOUT_FLAG];
    end
  end

  // Error request and transmit address
  always @(posedge core_clk) begin
    if (srst) begin
      error_irq_request <= 1'b0;
      tx_address_byte   <= 8'h00;
      tx_address_low    <= 8'h00;
    end else begin
      error_irq_request <= nack_irq_src || bto_irq_src;
      // Transmit address outputs
      tx_address_byte   <= address_buffer_high;
      tx_address_low    <= ctrl_mode ? address_buffer_low : 8'h00;
    end
  end

  // AXI read path
  always @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ICTO_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= in_map_ar ? `ICTO_RESP_OKAY : `ICTO_RESP_SLVERR;
        // Read data select
        case (ar_idx)
          `ICTO_IDX_CNT:  s_axi_rdata <= {16'h0000, byte_counter};
          `ICTO_IDX_ADB0: s_axi_rdata <= {24'h000000, address_buffer_low};
          `ICTO_IDX_ADB1: s_axi_rdata <= {24'h000000, address_buffer_high};
          `ICTO_IDX_ERR:  s_axi_rdata <= {25'h0000000, bus_timeout_flag, 1'b0,
                                          nack_detect_flag, 1'b0, bus_timeout_irq_enable,
                                          1'b0, nack_detect_irq_enable};
          `ICTO_IDX_BTO:  s_axi_rdata <= {24'h000000, bus_timeout_setup};
          `ICTO_IDX_BAUD: s_axi_rdata <= {24'h000000, baud_prescaler};
          `ICTO_IDX_CLK:  s_axi_rdata <= {28'h0000000, module_clock_select};
          `ICTO_IDX_BTOC: s_axi_rdata <= {29'h00000000, timeout_clock_select};
          `ICTO_IDX_STAT: s_axi_rdata <= {31'h00000000, count_done_flag};
          default:        s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // icto_core
`default_nettype wire

// file: icto_far.sv
// Purpose: free-running clock sources for module and timeout clock selection
// Assumes: sources are unrelated in phase to core_clk
// Notes: module sources 20.6 ns period, timeout sources 41.4 ns period
`timescale 1ns/100ps
`default_nettype none
module icto_far (
  // Source clocks
  output var logic [13:2] module_clk_src,
  output var logic [5:1]  timeout_clk_src
);
  initial begin
    module_clk_src = 12'h000;
    timeout_clk_src = 5'h00;
  end
  always #10.3 module_clk_src = ~module_clk_src;
  always #20.7 timeout_clk_src = ~timeout_clk_src;
endmodule // icto_far
`default_nettype wire

// file: icto_core_asserts.sv
// Purpose: port checks for bus handshakes, timeout reset, count flag, address out
// Assumes: one clock domain, srst synchronous active high
// Notes: bound from the testbench top
`timescale 1ns/100ps
`default_nettype none
module icto_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // Register bus
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_bvalid, s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Serial side
  input wire logic [2:0]  mode,
  input wire logic        scl_fall_9th, bus_busy, count_done_flag, serial_module_reset,
  input wire logic [7:0]  tx_address_low
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
    |-> ##[1:4] s_axi_bvalid) else $error("write answer late");
  awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  reset_pulse_a: assert property (serial_module_reset |=> !serial_module_reset)
    else $error("module reset held");
  reset_cause_a: assert property (serial_module_reset
    |-> $past(bus_busy) || $past(bus_busy, 2)) else $error("reset while bus idle");
  count_flag_a: assert property ($rose(count_done_flag) |-> $past(scl_fall_9th))
    else $error("count flag without 9th edge");
  txlow_zero_a: assert property (mode[2:1] != 2'b10 && $past(mode[2:1]) != 2'b10
    |-> tx_address_low == 8'h00) else $error("low address out of mode");
endmodule // icto_chk
`default_nettype wire

// file: tb_i2c_clock_count_timeout_addrbuf.sv
// Purpose: register-level tests of clock select, count, timeout and address buffers
// Assumes: icto_core with AXI4-Lite at byte address four times index
// Notes: timeout sources run at about 8 core cycles per period
`timescale 1ns/100ps
`default_nettype none
`include "icto_map.vh"
module tb_i2c_clock_count_timeout_addrbuf;
  logic        core_clk, srst, receiving, nack_addr_mismatch, bus_busy;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [13:2] module_clk_src;
  logic [5:1]  timeout_clk_src;
  logic [2:0]  mode;
  logic [8:0]  ev;
  logic [7:0]  addr_rx_byte, tx_address_byte, tx_address_low;
  logic        prescaled_clk_tick, count_done_flag, serial_module_reset, error_irq_request;
  int          n_mismatch, compares, nt;
  icto_core dut (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .module_clk_src,
    .timeout_clk_src, .mode, .receiving, .scl_fall_8th(ev[0]), .scl_fall_9th(ev[1]),
    .nack_seen(ev[2]), .nack_addr_mismatch, .transmit_write_error(ev[3]),
    .receive_read_error(ev[4]), .transmit_underflow(ev[5]), .receive_overflow(ev[6]),
    .bus_busy, .addr_low_valid(ev[7]), .addr_high_valid(ev[8]), .addr_rx_byte,
    .prescaled_clk_tick, .count_done_flag, .serial_module_reset, .error_irq_request,
    .tx_address_byte, .tx_address_low);
  icto_far far (.module_clk_src, .timeout_clk_src);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge core_clk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    @(posedge core_clk);
    s_axi_araddr <= {a, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, r);
  endtask
  task automatic pulse(input logic [8:0] p);
    @(posedge core_clk);
    ev <= p;
    @(posedge core_clk);
    ev <= 9'h000;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic ticks(input logic [3:0] c, input logic [7:0] b);
    wr(`ICTO_IDX_CLK, {28'h0, c});
    wr(`ICTO_IDX_BAUD, {24'h0, b});
    repeat (16) @(posedge core_clk);
    nt = 0;
    repeat (40) begin
      @(posedge core_clk);
      nt += prescaled_clk_tick;
    end
  endtask
  task automatic tmo(input logic [2:0] c, input logic [7:0] b, input int lo, hi,
                     input logic rs);
    int t, r;
    wr(`ICTO_IDX_BTOC, {29'h0, c});
    wr(`ICTO_IDX_BTO, {24'h0, b});
    wr(`ICTO_IDX_ERR, 32'h4);
    bus_busy <= 1'b1;
    t = 0;
    r = 0;
    while (!error_irq_request && t < hi) begin
      @(posedge core_clk);
      t++;
      r += serial_module_reset;
    end
    bus_busy <= 1'b0;
    chk("timeout time", lo < hi ? (t >= lo && t < hi) : (t == hi), 1);
    chk("recovery", r, rs);
    wr(`ICTO_IDX_ERR, 32'h0);
  endtask
  initial begin
    #100us;
    n_mismatch++;
    conclude;
  end
  initial begin
    {n_mismatch, compares} = '0;
    {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mode, ev, addr_rx_byte} = '0;
    {receiving, nack_addr_mismatch, bus_busy} = '0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd(`ICTO_IDX_CNT, 0);
    rd(`ICTO_IDX_BTO, 0);
    rd(`ICTO_IDX_ADB1, 0);
    rd(12'h291, 0, `ICTO_RESP_SLVERR);
    wr(12'h291, 32'hFF, `ICTO_RESP_SLVERR);
    ticks(4'h0, 8'h00); chk("ticks", nt, 10);
    ticks(4'h1, 8'h00); chk("ticks", nt, 40);
    ticks(4'h1, 8'h03); chk("ticks", nt, 10);
    ticks(4'h0, 8'h01); chk("ticks", nt, 5);
    ticks(4'hE, 8'h00); chk("ticks", nt, 0);
    ticks(4'hF, 8'h00); chk("ticks", nt, 0);
    for (int c = 2; c < 14; c++) begin
      ticks(c[3:0], 8'h00);
      chk("source ticks", nt > 6, 1);
    end
    wr(`ICTO_IDX_CNT, 32'h0001A5C3);
    rd(`ICTO_IDX_CNT, 32'h0000A5C3);
    wr(`ICTO_IDX_CNT, 32'h2);
    receiving <= 1'b1;
    pulse(9'h002); rd(`ICTO_IDX_CNT, 2);
    pulse(9'h001); rd(`ICTO_IDX_CNT, 1);
    receiving <= 1'b0;
    pulse(9'h001); rd(`ICTO_IDX_CNT, 1);
    chk("count flag", count_done_flag, 0);
    pulse(9'h002); rd(`ICTO_IDX_CNT, 0);
    pulse(9'h002); rd(`ICTO_IDX_STAT, 1);
    wr(`ICTO_IDX_STAT, 1);
    rd(`ICTO_IDX_STAT, 0);
    wr(`ICTO_IDX_ERR, 32'h1);
    nack_addr_mismatch <= 1'b1;
    pulse(9'h004); rd(`ICTO_IDX_ERR, 32'h1);
    chk("irq", error_irq_request, 0);
    nack_addr_mismatch <= 1'b0;
    pulse(9'h004); rd(`ICTO_IDX_ERR, 32'h11);
    chk("irq", error_irq_request, 1);
    for (int i = 0; i < 4; i++) begin
      wr(`ICTO_IDX_ERR, 32'h0);
      pulse(9'h008 << i); rd(`ICTO_IDX_ERR, 32'h10);
      chk("irq", error_irq_request, 0);
    end
    tmo(3'h1, 8'hC3, 16, 36, 1);
    tmo(3'h2, 8'h42, 8, 28, 0);
    tmo(3'h3, 8'h01, 256, 272, 0);
    tmo(3'h4, 8'h41, 0, 20, 0);
    tmo(3'h5, 8'h41, 0, 20, 0);
    tmo(3'h0, 8'h41, 600, 600, 0);
    tmo(3'h6, 8'h41, 600, 600, 0);
    tmo(3'h7, 8'h41, 600, 600, 0);
    addr_rx_byte <= 8'hA5;
    pulse(9'h080); rd(`ICTO_IDX_ADB0, 32'hA5);
    wr(`ICTO_IDX_ADB0, 32'h11); rd(`ICTO_IDX_ADB0, 32'hA5);
    wr(`ICTO_IDX_ADB1, 32'h22); rd(`ICTO_IDX_ADB1, 0);
    mode <= 3'h2;
    addr_rx_byte <= 8'h3C;
    pulse(9'h080);
    addr_rx_byte <= 8'hF3;
    pulse(9'h100); rd(`ICTO_IDX_ADB1, 32'hF3);
    rd(`ICTO_IDX_ADB0, 32'h3C);
    mode <= 3'h5;
    wr(`ICTO_IDX_ADB0, 32'h5A); rd(`ICTO_IDX_ADB0, 32'h5A);
    wr(`ICTO_IDX_ADB1, 32'hF1);
    repeat (2) @(posedge core_clk);
    chk("tx low", tx_address_low, 8'h5A);
    chk("tx high", tx_address_byte, 8'hF1);
    mode <= 3'h4;
    wr(`ICTO_IDX_ADB1, 32'h42); rd(`ICTO_IDX_ADB1, 32'h42);
    chk("tx high", tx_address_byte, 8'h42);
    chk("tx low", tx_address_low, 8'h5A);
    mode <= 3'h6;
    wr(`ICTO_IDX_ADB1, 32'h24); rd(`ICTO_IDX_ADB1, 32'h24);
    chk("tx low", tx_address_low, 8'h00);
    conclude;
  end
endmodule // tb_i2c_clock_count_timeout_addrbuf
bind icto_core icto_chk u_chk (.core_clk, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .mode, .scl_fall_9th,
  .bus_busy, .count_done_flag, .serial_module_reset, .tx_address_low);
`default_nettype wire
